// File: core/cam_pkg.sv
// Constants for the counter array mode and PWM configuration block
package cam_pkg;
    // Register addresses on the special function register bus
    localparam logic [7:0] CAM_ADDR_MODE     = 8'h00_d9;
    localparam logic [7:0] CAM_ADDR_PWM      = 8'h00_df;
    localparam logic [7:0] CAM_ADDR_CCH      = 8'h00_fc;
    localparam logic [7:0] CAM_ADDR_CCL      = 8'h00_fb;
    localparam logic [7:0] CAM_ADDR_CTR_LO   = 8'h00_f9;
    localparam logic [7:0] CAM_ADDR_CTR_HI   = 8'h00_fa;
    localparam logic [7:0] CAM_ADDR_FLAGS    = 8'h00_d8;
    // Mode register fields
    localparam int CAM_MD_IDLE     = 7;
    localparam int CAM_MD_WDE      = 6;
    localparam int CAM_MD_WDL      = 5;
    localparam int CAM_MD_TB_LSB   = 1;
    localparam int CAM_MD_OVIE     = 0;
    localparam logic [7:0] CAM_MD_RESET    = 8'h00_40;
    localparam logic [7:0] CAM_MD_WMASK    = 8'h00_ef;
    // PWM configuration fields
    localparam int CAM_PW_RSEL     = 7;
    localparam int CAM_PW_COVIE    = 6;
    localparam int CAM_PW_CYCLE_OVERFLOW_FLAG     = 5;
    localparam logic [7:0] CAM_PW_RESET    = 8'h00_00;
    // Flags register field
    localparam int CAM_FL_OVF      = 7;
    // Clock dividers
    localparam logic [3:0] CAM_DIV12 = 4'h0_b;
    localparam logic [1:0] CAM_DIV4  = 2'h3;
    // Timebase source codes
    typedef enum logic [2:0] {
        CAM_TB_SYS12 = 3'h0,
        CAM_TB_SYS4  = 3'h1,
        CAM_TB_T0    = 3'h2,
        CAM_TB_EXTIN = 3'h3,
        CAM_TB_SYS   = 3'h4,
        CAM_TB_EXT8  = 3'h5,
        CAM_TB_RTC8  = 3'h6,
        CAM_TB_RSVD  = 3'h7
    } cam_tb_t;
endpackage

// File: core/cam_sync.sv
// Two-stage synchroniser with edge detector behind it
`timescale 1ns/100ps
`default_nettype none
module cam_sync
    import cam_pkg::*;
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    // Asynchronous level in, synchronised level, falling edge and rising edge out
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_fall,
    output logic      o_rise
);
    logic meta_q;    // First stage, read only by stage two
    logic sync_q;    // Second stage
    logic last_q;    // Previous synchronised level
    logic meta_d;
    logic sync_d;
    logic last_d;

    // Next values of the chain
    always_comb
    begin
        meta_d = i_async;
        sync_d = meta_q;
        last_d = sync_q;
    end

    // Register the chain
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    assign o_level = sync_q;
    assign o_fall  = last_q & ~sync_q;
    assign o_rise  = ~last_q & sync_q;
endmodule
`default_nettype wire

// File: core/cam_core.sv
// Counter array mode control, timebase, counter, flags and reload routing
// Holds the mode and PWM configuration registers, the timebase prescaler,
// the 16-bit counter and its two overflow flags. All state sits behind a
// reset copy released through two flops, so no register sees a runt release.
`timescale 1ns/100ps
`default_nettype none
module cam_core
    import cam_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Special function register bus
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    // System status and count sources
    input  wire logic       i_cpu_idle,
    input  wire logic       i_timer0_ovf,
    input  wire logic       i_ext_count_in,
    input  wire logic       i_ext_clk_div8,
    input  wire logic       i_rtc_clk_div8,
    // Outputs towards the rest of the array
    output logic            o_irq,
    output logic      [15:0] o_counter,
    output logic            o_count_tick,
    output logic            o_watchdog_enable,
    output logic            o_watchdog_lock,
    output logic      [15:0] o_reload_value,
    output logic      [1:0] o_cycle_length_select
);
    // Reset release
    // Assert is immediate, release waits two edges so every flop leaves
    // reset on the same clock edge
    logic       rst_m_q;     // Reset stage one
    logic       rst_s_q;     // Reset stage two, used by all logic
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // Synchronised pins
    logic ext_fall;          // Falling edge on external count input
    logic ext8_rise;         // Divided external clock edge
    logic rtc8_rise;         // Divided real-time clock edge
    logic idle_s;            // Idle level, synchronised

    // External count input idles high; its falling edges are counted
    cam_sync u_ext (
        .i_clock (i_clock),
        .i_rst_n (rst_s_q),
        .i_async (i_ext_count_in),
        .o_level (),
        .o_fall  (ext_fall),
        .o_rise  ()
    );
    // Divided external clock; one count per rising edge
    cam_sync u_ext8 (
        .i_clock (i_clock),
        .i_rst_n (rst_s_q),
        .i_async (i_ext_clk_div8),
        .o_level (),
        .o_fall  (),
        .o_rise  (ext8_rise)
    );
    // Divided real-time clock; one count per rising edge
    cam_sync u_rtc8 (
        .i_clock (i_clock),
        .i_rst_n (rst_s_q),
        .i_async (i_rtc_clk_div8),
        .o_level (),
        .o_fall  (),
        .o_rise  (rtc8_rise)
    );
    // Idle level from the core's own power control
    cam_sync u_idle (
        .i_clock (i_clock),
        .i_rst_n (rst_s_q),
        .i_async (i_cpu_idle),
        .o_level (idle_s),
        .o_fall  (),
        .o_rise  ()
    );

    // State registers
    logic [7:0]  mode_q, mode_d;        // Mode control register
    logic [7:0]  pwm_q, pwm_d;          // PWM configuration register
    logic        ovf_q, ovf_d;          // Counter overflow flag
    logic [15:0] ctr_q, ctr_d;          // Main 16-bit counter
    logic [15:0] cc_q, cc_d;            // Capture/compare value
    logic [15:0] ar_q, ar_d;            // Auto-reload value
    logic [3:0]  div_q, div_d;          // System clock prescaler
    logic        tick_q, tick_d;        // Count tick, registered
    logic [7:0]  rdata_q, rdata_d;      // Read data
    logic        irq_q, irq_d;          // Interrupt request

    // Derived controls
    logic        wde;                   // Watchdog enabled
    logic        tick;                  // Counter advance this cycle
    logic        suspend;               // Array halted in idle
    logic        cyc_ovf;               // Selected bit overflow
    logic [16:0] ctr_inc;               // Counter plus one with carry
    logic [11:0] low_inc;               // Low bits plus one
    cam_tb_t     tb_sel;                // Timebase source

    // Timebase choice, idle suspend and cycle overflow detect
    // Reserved timebase code never ticks, so the counter simply stops
    always_comb
    begin
        wde     = mode_q[CAM_MD_WDE];
        tb_sel  = cam_tb_t'(mode_q[CAM_MD_TB_LSB +: 3]);
        suspend = mode_q[CAM_MD_IDLE] & idle_s;
        // Timebase multiplexer
        case (tb_sel)
            CAM_TB_SYS12: tick = (div_q == CAM_DIV12);
            CAM_TB_SYS4:  tick = (div_q[1:0] == CAM_DIV4);
            CAM_TB_T0:    tick = i_timer0_ovf;
            CAM_TB_EXTIN: tick = ext_fall;
            CAM_TB_SYS:   tick = 1'b1;
            CAM_TB_EXT8:  tick = ext8_rise;
            CAM_TB_RTC8:  tick = rtc8_rise;
            default:      tick = 1'b0;                             // Reserved
        endcase
        tick    = tick & ~suspend;
        ctr_inc = {1'b0, ctr_q} + 17'd1;
        low_inc = {1'b0, ctr_q[10:0]} + 12'd1;
        // Cycle overflow on the carry out of the selected length
        case (pwm_q[1:0])
            2'h0:    cyc_ovf = tick & (ctr_q[7:0] == 8'h00_ff);
            2'h1:    cyc_ovf = tick & (ctr_q[8:0] == 9'h1_ff);
            2'h2:    cyc_ovf = tick & (ctr_q[9:0] == 10'h3_ff);
            default: cyc_ovf = tick & low_inc[11];
        endcase
    end

    // Prescaler, counter and flag next values
    // A counter write wins over a tick in the same cycle, but the wrap
    // carry of that tick still sets the overflow flag
    always_comb
    begin
        div_d  = suspend ? div_q : ((div_q == CAM_DIV12) ? 4'h0 : div_q + 4'h1);
        ctr_d  = tick ? ctr_inc[15:0] : ctr_q;
        tick_d = tick;
        ovf_d  = ovf_q;
        // Software write to the flags register may clear or set the flag
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_FLAGS)
            ovf_d = i_sfr_wdata[CAM_FL_OVF];
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_CTR_LO)
            ctr_d = {ctr_q[15:8], i_sfr_wdata};
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_CTR_HI)
            ctr_d = {i_sfr_wdata, ctr_q[7:0]};
        // Hardware set wins over a software clear
        if (tick && ctr_inc[16])
            ovf_d = 1'b1;
    end

    // Register writes and reload routing
    // While the watchdog runs, idle control, timebase and interrupt enable
    // are frozen so software cannot loosen it by accident
    always_comb
    begin
        mode_d = mode_q;
        pwm_d  = pwm_q;
        cc_d   = cc_q;
        ar_d   = ar_q;
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_MODE)
        begin
            if (wde)
            begin
                // Only the enable and lock bits stay writable
                mode_d[CAM_MD_WDL] = mode_q[CAM_MD_WDL] | i_sfr_wdata[CAM_MD_WDL];
                if (!mode_q[CAM_MD_WDL])
                    mode_d[CAM_MD_WDE] = i_sfr_wdata[CAM_MD_WDE];
                // Lock only sets here; only a reset clears it
            end
            else
            begin
                mode_d = i_sfr_wdata & CAM_MD_WMASK;
            end
            // Setting the lock also turns the watchdog on
            if (i_sfr_wdata[CAM_MD_WDL])
                mode_d[CAM_MD_WDE] = 1'b1;
        end
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_PWM)
        begin
            pwm_d[CAM_PW_RSEL]  = i_sfr_wdata[CAM_PW_RSEL];
            pwm_d[CAM_PW_COVIE] = i_sfr_wdata[CAM_PW_COVIE];
            pwm_d[CAM_PW_CYCLE_OVERFLOW_FLAG]  = i_sfr_wdata[CAM_PW_CYCLE_OVERFLOW_FLAG];
            pwm_d[1:0]          = i_sfr_wdata[1:0];
        end
        if (cyc_ovf)
            pwm_d[CAM_PW_CYCLE_OVERFLOW_FLAG] = 1'b1;
        // Same addresses reach reload or compare registers
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_CCL)
        begin
            if (pwm_q[CAM_PW_RSEL])
                ar_d[7:0] = i_sfr_wdata;
            else
                cc_d[7:0] = i_sfr_wdata;
        end
        if (i_sfr_wr && i_sfr_addr == CAM_ADDR_CCH)
        begin
            if (pwm_q[CAM_PW_RSEL])
                ar_d[15:8] = i_sfr_wdata;
            else
                cc_d[15:8] = i_sfr_wdata;
        end
    end

    // Read data and interrupt
    // Read data is registered: a strobe shows its answer one cycle later
    // and the bus reads zero in every other cycle
    always_comb
    begin
        rdata_d = 8'h00_00;
        if (i_sfr_rd)
        begin
            case (i_sfr_addr)
                CAM_ADDR_MODE:   rdata_d = mode_q & CAM_MD_WMASK;
                CAM_ADDR_PWM:    rdata_d = {pwm_q[7:5], 3'h0, pwm_q[1:0]};
                CAM_ADDR_FLAGS:  rdata_d = {ovf_q, 7'h00};
                CAM_ADDR_CTR_LO: rdata_d = ctr_q[7:0];
                CAM_ADDR_CTR_HI: rdata_d = ctr_q[15:8];
                CAM_ADDR_CCL:    rdata_d = pwm_q[CAM_PW_RSEL] ? ar_q[7:0] : cc_q[7:0];
                CAM_ADDR_CCH:    rdata_d = pwm_q[CAM_PW_RSEL] ? ar_q[15:8] : cc_q[15:8];
                default:         rdata_d = 8'h00_00;
            endcase
        end
        // Built from next values so the request lines up with the
        // registered flags in the same cycle
        irq_d = (ovf_d & mode_d[CAM_MD_OVIE])
              | (pwm_d[CAM_PW_CYCLE_OVERFLOW_FLAG] & pwm_d[CAM_PW_COVIE]);
    end

    // Register all state
    // Enable comes back set and lock clear, so the watchdog runs from reset
    always_ff @(posedge i_clock or negedge rst_s_q)
    begin
        if (!rst_s_q)
        begin
            mode_q  <= CAM_MD_RESET;
            pwm_q   <= CAM_PW_RESET;
            ovf_q   <= 1'b0;
            ctr_q   <= 16'h0000;
            cc_q    <= 16'h0000;
            ar_q    <= 16'h0000;
            div_q   <= 4'h0;
            tick_q  <= 1'b0;
            rdata_q <= 8'h00_00;
            irq_q   <= 1'b0;
        end
        else
        begin
            mode_q  <= mode_d;
            pwm_q   <= pwm_d;
            ovf_q   <= ovf_d;
            ctr_q   <= ctr_d;
            cc_q    <= cc_d;
            ar_q    <= ar_d;
            div_q   <= div_d;
            tick_q  <= tick_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_sfr_rdata           = rdata_q;
    assign o_irq                 = irq_q;
    assign o_counter             = ctr_q;
    assign o_count_tick          = tick_q;
    assign o_watchdog_enable     = mode_q[CAM_MD_WDE];
    assign o_watchdog_lock       = mode_q[CAM_MD_WDL];
    assign o_reload_value        = ar_q;
    assign o_cycle_length_select = pwm_q[1:0];
endmodule
`default_nettype wire

// File: tb/cam_monitor.sv
// Port-level checker for the counter array mode block
`timescale 1ns/100ps
`default_nettype none
module cam_monitor
    import cam_pkg::*;
(
    // Clock, reset and register bus
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic        i_sfr_wr,
    input wire logic        i_sfr_rd,
    input wire logic [7:0]  i_sfr_wdata,
    // Observed outputs
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        o_irq,
    input wire logic [15:0] o_counter,
    input wire logic        o_watchdog_enable,
    input wire logic        o_watchdog_lock,
    input wire logic [15:0] o_reload_value,
    input wire logic [1:0]  o_cycle_length_select
);
    // Mode register write strobe
    wire logic md_wr = i_sfr_wr && i_sfr_addr == CAM_ADDR_MODE;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    wd_reset_on_a: assert property ($rose(i_rst_n) |-> o_watchdog_enable)
        else $error("watchdog not enabled out of reset");
    lock_keeps_en_a: assert property (o_watchdog_lock |=> o_watchdog_lock && o_watchdog_enable)
        else $error("locked watchdog was disabled");
    lock_write_a: assert property (md_wr && i_sfr_wdata[5] |=> o_watchdog_lock && o_watchdog_enable)
        else $error("lock write did not lock and enable");
    wd_disable_a: assert property (md_wr && i_sfr_wdata[6:5] == 2'b00
        && !o_watchdog_lock |=> !o_watchdog_enable)
        else $error("unlocked watchdog did not disable");
    mode_read_a: assert property (i_sfr_rd && i_sfr_addr == CAM_ADDR_MODE
        |=> o_sfr_rdata[4] == 1'b0
        && o_sfr_rdata[6:5] == {$past(o_watchdog_enable), $past(o_watchdog_lock)})
        else $error("mode read data wrong");
    cycle_overflow_flag_irq_a: assert property (i_sfr_wr && i_sfr_addr == CAM_ADDR_PWM && i_sfr_wdata[6:5] == 2'b11
        |-> ##[1:2] o_irq)
        else $error("cycle overflow request missing");
    clsel_write_a: assert property ($changed(o_cycle_length_select)
        |-> $past(i_sfr_wr && i_sfr_addr == CAM_ADDR_PWM))
        else $error("cycle length changed without write");
    reload_write_a: assert property ($changed(o_reload_value)
        |-> $past(i_sfr_wr && (i_sfr_addr == CAM_ADDR_CCL || i_sfr_addr == CAM_ADDR_CCH)))
        else $error("reload value changed without write");
    count_step_a: assert property (!$past(i_sfr_wr) && o_counter != $past(o_counter)
        |-> o_counter == $past(o_counter) + 16'h0001)
        else $error("counter moved by other than one");
endmodule

bind cam_core cam_monitor mon_u (.i_clock, .i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
    .o_irq, .o_counter, .o_watchdog_enable, .o_watchdog_lock, .o_reload_value, .o_cycle_length_select);
`default_nettype wire

// File: tb/cam_cpu_model.sv
// Processor core model that drives the register bus
`timescale 1ns/100ps
`default_nettype none
module cam_cpu_model
    import cam_pkg::*;
(
    // Clock
    input  wire logic       i_clock,
    // Register bus towards the block
    output logic      [7:0] o_sfr_addr,
    output logic            o_sfr_wr,
    output logic            o_sfr_rd,
    output logic      [7:0] o_sfr_wdata,
    input  wire logic [7:0] i_sfr_rdata
);
    // Idle bus from time zero
    initial
    begin
        o_sfr_addr  = 8'h00;
        o_sfr_wr    = 1'b0;
        o_sfr_rd    = 1'b0;
        o_sfr_wdata = 8'h00;
    end
    // One write; software disables the watchdog and clears flags this way
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_sfr_addr  = a;
        o_sfr_wdata = d;
        o_sfr_wr    = 1'b1;
        @(negedge i_clock);
        o_sfr_wr    = 1'b0;
        o_sfr_addr  = 8'h00;
        o_sfr_wdata = ~d;
    endtask
    // One read, data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clock);
        o_sfr_addr = a;
        o_sfr_rd   = 1'b1;
        @(negedge i_clock);
        o_sfr_rd   = 1'b0;
        o_sfr_addr = 8'h00;
        d          = i_sfr_rdata;
    endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking testbench for the counter array mode block
`timescale 1ns/100ps
`default_nettype none
module testbench
    import cam_pkg::*;
;
    logic        clk   = 1'b0;  // System clock
    logic        rst_n = 1'b0;  // Reset, active low
    logic        idle  = 1'b0;  // CPU idle level
    logic [3:0]  src   = 4'h2;  // Rtc8, ext8, ext input, timer0
    logic [7:0]  addr, wdata, rdata;
    logic        wr, rd, irq, tick, wd_en, wd_lock;
    logic [15:0] counter, reload;
    logic [1:0]  clsel;
    int          mismatches = 0;
    int          compares   = 0;
    // Expected advance over a 36 cycle window, per timebase code
    logic [15:0] span_exp [7] = '{16'h0003, 16'h0009, 16'h0003, 16'h0003, 16'h0024, 16'h0003, 16'h0003};

    // 100 ns clock
    always #50 clk = ~clk;

    cam_cpu_model cpu_u (.i_clock(clk), .o_sfr_addr(addr), .o_sfr_wr(wr), .o_sfr_rd(rd), .o_sfr_wdata(wdata),
        .i_sfr_rdata(rdata));
    cam_core dut_u (.i_clock(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_cpu_idle(idle), .i_timer0_ovf(src[0]),
        .i_ext_count_in(src[1]), .i_ext_clk_div8(src[2]), .i_rtc_clk_div8(src[3]), .o_irq(irq),
        .o_counter(counter), .o_count_tick(tick), .o_watchdog_enable(wd_en), .o_watchdog_lock(wd_lock),
        .o_reload_value(reload), .o_cycle_length_select(clsel));

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read and compare the masked bits
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        cpu_u.rd(a, v);
        chk({8'h00, v & m}, {8'h00, e});
    endtask
    // Reset held for 12 cycles
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // Mode write, then count advance over a window with three edges of every source
    task automatic span(input logic [7:0] md, input logic [15:0] exp);
        logic [15:0] c0;
        cpu_u.wr(CAM_ADDR_MODE, md);
        repeat (4) @(negedge clk);
        c0 = counter;
        repeat (3)
        begin
            src = 4'hd;  // Edges spaced well under a quarter rate
            @(negedge clk);
            src = 4'hc;
            repeat (3) @(negedge clk);
            src = 4'h2;
            repeat (4) @(negedge clk);
        end
        repeat (12) @(negedge clk);
        chk(counter - c0, exp);
    endtask
    // Stop counter, load it, set pwm and clear flags, then run at system clock
    task automatic setctr(input logic [15:0] c, input logic [7:0] pw);
        cpu_u.wr(CAM_ADDR_MODE, 8'h04);
        cpu_u.wr(CAM_ADDR_CTR_LO, c[7:0]);
        cpu_u.wr(CAM_ADDR_CTR_HI, c[15:8]);
        cpu_u.wr(CAM_ADDR_PWM, pw);
        cpu_u.wr(CAM_ADDR_FLAGS, 8'h00);
        cpu_u.wr(CAM_ADDR_MODE, 8'h08);
        repeat (30) @(negedge clk);
    endtask
    // Verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        do_reset();
        chk(16'(wd_en), 16'h0001);
        rdc(CAM_ADDR_MODE, 8'hff, 8'h40);
        rdc(CAM_ADDR_PWM, 8'hff, 8'h00);
        cpu_u.wr(CAM_ADDR_MODE, 8'h9f);
        rdc(CAM_ADDR_MODE, 8'hff, 8'h00);
        cpu_u.wr(CAM_ADDR_MODE, 8'h9f);
        rdc(CAM_ADDR_MODE, 8'hff, 8'h8f);
        for (int i = 0; i < 7; i++)
            span({4'h0, 3'(i), 1'b0}, span_exp[i]);
        idle = 1'b1;
        span(8'h88, 16'h0000);
        chk(16'(tick), 16'h0000);
        span(8'h08, 16'h0024);
        chk(16'(tick), 16'h0001);
        idle = 1'b0;
        setctr(16'hfff0, 8'h00);
        chk(16'(irq), 16'h0000);
        rdc(CAM_ADDR_FLAGS, 8'h80, 8'h80);
        cpu_u.wr(CAM_ADDR_MODE, 8'h09);
        repeat (3) @(negedge clk);
        chk(16'(irq), 16'h0001);
        cpu_u.wr(CAM_ADDR_FLAGS, 8'h00);
        repeat (3) @(negedge clk);
        chk(16'(irq), 16'h0000);
        rdc(CAM_ADDR_PWM, 8'h20, 8'h20);
        cpu_u.wr(CAM_ADDR_PWM, 8'h60);
        repeat (3) @(negedge clk);
        chk(16'(irq), 16'h0001);
        cpu_u.wr(CAM_ADDR_PWM, 8'h40);
        repeat (3) @(negedge clk);
        chk(16'(irq), 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            setctr(16'((1 << (8 + k)) - 16), 8'(k));
            rdc(CAM_ADDR_PWM, 8'hff, 8'(k) | 8'h20);
            chk({14'h0000, clsel}, 16'(k));
            if (k > 0)
            begin
                setctr(16'((1 << (8 + k)) + 240), 8'(k));
                rdc(CAM_ADDR_PWM, 8'hff, 8'(k));
            end
        end
        cpu_u.wr(CAM_ADDR_PWM, 8'h80);
        cpu_u.wr(CAM_ADDR_CCL, 8'h34);
        cpu_u.wr(CAM_ADDR_CCH, 8'h12);
        chk(reload, 16'h1234);
        rdc(CAM_ADDR_CCH, 8'hff, 8'h12);
        cpu_u.wr(CAM_ADDR_PWM, 8'h00);
        cpu_u.wr(CAM_ADDR_CCL, 8'h55);
        chk(reload, 16'h1234);
        rdc(CAM_ADDR_CCL, 8'hff, 8'h55);
        rdc(8'h01, 8'hff, 8'h00);
        cpu_u.wr(CAM_ADDR_MODE, 8'h20);
        rdc(CAM_ADDR_MODE, 8'hff, 8'h60);
        chk(16'(wd_lock), 16'h0001);
        cpu_u.wr(CAM_ADDR_MODE, 8'h00);
        rdc(CAM_ADDR_MODE, 8'hff, 8'h60);
        do_reset();
        chk(16'(wd_lock), 16'h0000);
        cpu_u.wr(CAM_ADDR_MODE, 8'h00);
        rdc(CAM_ADDR_MODE, 8'hff, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
